// ===== shared/idt_pkg.sv
// constants, types and helpers shared by the instruction decode and timing logic
// assumes a single clock domain; words arrive from program memory one per instruction cycle
package idt_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_PER_ICYC = 4;
  localparam int ICYC_NS = CLK_PERIOD_NS * OSC_PER_ICYC;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_ICYC - 1);

  // ----------------------------------------------------------------
  // instruction set sizes
  // ----------------------------------------------------------------
  localparam int STD_SET_SIZE = 75;
  localparam int EXT_SET_SIZE = 8;
  localparam int STD_DOUBLE_WORDS = 4;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int FILE_MSB = 7;
  localparam int ACC_BIT = 8;
  localparam int DEST_BIT = 9;
  localparam int BIT_MSB = 11;
  localparam int BIT_LSB = 9;
  localparam int LIT_MSB = 7;
  localparam int PTR_LOAD_LSB = 4;
  localparam int PTR_EXT_LSB = 6;
  localparam int CALL_FAST_BIT = 8;
  localparam int RET_FAST_BIT = 0;
  localparam int TBL_MSB = 1;
  localparam int BRA_MSB = 10;
  localparam int WORD2_MSB = 11;
  localparam int NIB_LSB = 12;
  localparam logic [3:0] TAIL_NIB = 4'hF;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [1:0] {
    GRP_BYTE = 2'h0,
    GRP_BIT = 2'h1,
    GRP_LIT = 2'h2,
    GRP_CTRL = 2'h3
  } idt_group_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_FLUSH = 2'h1,
    ST_SECOND = 2'h2
  } idt_state_t;

  function automatic logic idt_is_tail(input logic [15:0] w);
    idt_is_tail = (w[15:NIB_LSB] == TAIL_NIB);
  endfunction

endpackage

// ===== design/idt_phase_gen.sv
// four-phase sequencer that cuts the oscillator into instruction cycles
// assumes clk_i is the oscillator clock
`timescale 1ns/10ps
`default_nettype none
module idt_phase_gen (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // phase
  output logic [1:0] phase_o,
  output logic cycle_end_o
);

  logic [1:0] phase_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign phase_o = phase_reg;
  assign cycle_end_o = (phase_reg == idt_pkg::PHASE_LAST);

  a_cycle_four: assert property (@(posedge clk_i) disable iff (rst_i)
    cycle_end_o |=> !cycle_end_o [*3] ##1 cycle_end_o)
    else $error("instruction cycle is not four clocks");

endmodule
`default_nettype wire

// ===== design/idt_field_split.sv
// combinational classifier for one instruction word
// assumes the word is stable for the cycle it is sampled in
`timescale 1ns/10ps
`default_nettype none
module idt_field_split (
  // word in
  input wire logic [15:0] word_i,
  input wire logic ext_mode_i,
  // classification
  output idt_pkg::idt_group_t group_o,
  output logic two_word_o,
  output logic skip_o,
  output logic cond_br_o,
  output logic jump_o,
  output logic working_register_we_o,
  output logic file_we_o,
  output logic illegal_o
);

  logic has_dest;
  logic ext_op;

  // ----------------------------------------------------------------
  // opcode table
  // ----------------------------------------------------------------
  always_comb begin
    group_o = idt_pkg::GRP_CTRL;
    two_word_o = 1'b0;
    skip_o = 1'b0;
    cond_br_o = 1'b0;
    jump_o = 1'b0;
    has_dest = 1'b0;
    file_we_o = 1'b0;
    working_register_we_o = 1'b0;
    illegal_o = 1'b0;
    ext_op = 1'b0;
    casez (word_i)
      16'h0014: begin
        jump_o = 1'b1;
        ext_op = 1'b1;
      end
      16'b0000_0000_0001_00??, 16'h00FF: jump_o = 1'b1;
      16'h00??: group_o = idt_pkg::GRP_CTRL;
      16'h010?: group_o = idt_pkg::GRP_LIT;
      16'h01??: illegal_o = 1'b1;
      16'b0000_001?_????_????: group_o = idt_pkg::GRP_BYTE;
      16'h0C??: begin
        jump_o = 1'b1;
        working_register_we_o = 1'b1;
      end
      16'h0D??: group_o = idt_pkg::GRP_LIT;
      16'b0000_1???_????_????: begin
        group_o = idt_pkg::GRP_LIT;
        working_register_we_o = 1'b1;
      end
      16'b0110_0???_????_????: begin
        group_o = idt_pkg::GRP_BYTE;
        skip_o = 1'b1;
      end
      16'b0110_1???_????_????: begin
        group_o = idt_pkg::GRP_BYTE;
        file_we_o = 1'b1;
      end
      16'b0010_11??_????_????, 16'b0011_11??_????_????, 16'b0100_1???_????_????: begin
        group_o = idt_pkg::GRP_BYTE;
        skip_o = 1'b1;
        has_dest = 1'b1;
      end
      // bit toggle shares the leading zero with the byte group, so it must win first
      16'b0111_????_????_????: begin
        group_o = idt_pkg::GRP_BIT;
        file_we_o = 1'b1;
      end
      16'b0???_????_????_????: begin
        group_o = idt_pkg::GRP_BYTE;
        has_dest = 1'b1;
      end
      16'b100?_????_????_????: begin
        group_o = idt_pkg::GRP_BIT;
        file_we_o = 1'b1;
      end
      16'b101?_????_????_????: begin
        group_o = idt_pkg::GRP_BIT;
        skip_o = 1'b1;
      end
      16'hC???: begin
        group_o = idt_pkg::GRP_BYTE;
        two_word_o = 1'b1;
        file_we_o = 1'b1;
      end
      16'hD???: jump_o = 1'b1;
      16'b1110_0???_????_????: cond_br_o = 1'b1;
      16'b1110_110?_????_????, 16'hEF??: begin
        two_word_o = 1'b1;
        jump_o = 1'b1;
      end
      16'b1110_1110_00??_????: begin
        group_o = idt_pkg::GRP_LIT;
        two_word_o = 1'b1;
      end
      16'b1110_100?_????_????: begin
        group_o = idt_pkg::GRP_LIT;
        ext_op = 1'b1;
        jump_o = (word_i[7:6] == 2'h3);
      end
      16'hEA??: begin
        group_o = idt_pkg::GRP_LIT;
        ext_op = 1'b1;
      end
      16'hEB??: begin
        group_o = idt_pkg::GRP_BYTE;
        two_word_o = 1'b1;
        file_we_o = 1'b1;
        ext_op = 1'b1;
      end
      16'hF???: group_o = idt_pkg::GRP_CTRL;
      default: illegal_o = 1'b1;
    endcase
    if (has_dest) begin
      working_register_we_o = !word_i[idt_pkg::DEST_BIT];
      file_we_o = word_i[idt_pkg::DEST_BIT];
    end
    // extended opcodes act as illegal no-ops unless the extended set is on
    if (ext_op && !ext_mode_i) begin
      illegal_o = 1'b1;
    end
    if (illegal_o) begin
      group_o = idt_pkg::GRP_CTRL;
      two_word_o = 1'b0;
      skip_o = 1'b0;
      jump_o = 1'b0;
      working_register_we_o = 1'b0;
      file_we_o = 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== design/idt_decode_timing.sv
// instruction register, operand fields and execute-cycle sequencing
// assumes program memory presents the next word by the last phase of each
// instruction cycle and the datapath gives its test result in that phase
`timescale 1ns/10ps
`default_nettype none
module idt_decode_timing (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // program memory and datapath
  input wire logic [15:0] prog_word_i,
  input wire logic cond_true_i,
  input wire logic ext_mode_i,
  // timing
  output logic [1:0] phase_o,
  output logic cycle_end_o,
  output logic nop_cycle_o,
  output logic second_cycle_o,
  // operand fields
  output logic [1:0] group_o,
  output logic [7:0] file_addr_o,
  output logic dest_file_o,
  output logic access_bank_o,
  output logic [2:0] bit_num_o,
  output logic [7:0] literal_o,
  output logic [1:0] file_select_pointer_o,
  output logic fast_mode_o,
  output logic [1:0] table_mode_o,
  output logic [11:0] second_word_o,
  // write strobes
  output logic working_register_we_o,
  output logic file_we_o,
  output logic alu_update_o,
  // program counter
  output logic pc_load_o,
  output logic [19:0] pc_target_o,
  output logic pc_relative_o,
  // retire
  output logic instr_done_o,
  output logic [1:0] instr_cycles_o
);

  idt_pkg::idt_group_t dec_group;
  logic dec_two;
  logic dec_skip;
  logic dec_cbr;
  logic dec_jump;
  logic dec_wwe;
  logic dec_fwe;
  logic dec_ill;

  logic [15:0] ex_word_reg;
  logic [15:0] ex_word2_reg;
  idt_pkg::idt_group_t ex_group_reg;
  logic ex_two_reg;
  logic ex_skip_reg;
  logic ex_cbr_reg;
  logic ex_jump_reg;
  logic ex_wwe_reg;
  logic ex_fwe_reg;
  logic ex_ill_reg;

  idt_pkg::idt_state_t state_reg;
  idt_pkg::idt_state_t state_next;
  logic [1:0] cyc_cnt_reg;
  logic instr_done_reg;
  logic [1:0] instr_cycles_reg;
  logic pc_load_reg;
  logic [19:0] pc_target_reg;
  logic pc_rel_reg;

  logic live;
  logic write_slot;
  logic taken;

  // ----------------------------------------------------------------
  // phase sequencer and word classifier
  // ----------------------------------------------------------------
  idt_phase_gen u_phase (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .phase_o(phase_o),
    .cycle_end_o(cycle_end_o)
  );

  idt_field_split u_split (
    .word_i(prog_word_i),
    .ext_mode_i(ext_mode_i),
    .group_o(dec_group),
    .two_word_o(dec_two),
    .skip_o(dec_skip),
    .cond_br_o(dec_cbr),
    .jump_o(dec_jump),
    .working_register_we_o(dec_wwe),
    .file_we_o(dec_fwe),
    .illegal_o(dec_ill)
  );

  // ----------------------------------------------------------------
  // execute sequencing
  // ----------------------------------------------------------------
  assign live = (state_reg == idt_pkg::ST_RUN);
  // skips and conditional branches only count as taken when cond_true_i is set; jumps always count
  assign taken = live && (ex_jump_reg || ((ex_skip_reg || ex_cbr_reg) && cond_true_i));

  always_comb begin
    state_next = idt_pkg::ST_RUN;
    unique case (state_reg)
      idt_pkg::ST_RUN: begin
        if (ex_two_reg) begin
          state_next = idt_pkg::ST_SECOND;
        end else if (taken) begin
          state_next = idt_pkg::ST_FLUSH;
        end
      end
      idt_pkg::ST_FLUSH: state_next = idt_pkg::ST_RUN;
      idt_pkg::ST_SECOND: state_next = idt_pkg::ST_RUN;
      default: state_next = idt_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= idt_pkg::ST_RUN;
    end else if (cycle_end_o) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  // during the second cycle the first word stays put so its fields remain visible
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ex_word_reg <= idt_pkg::RST_WORD;
      ex_group_reg <= idt_pkg::GRP_CTRL;
      ex_two_reg <= 1'b0;
      ex_skip_reg <= 1'b0;
      ex_cbr_reg <= 1'b0;
      ex_jump_reg <= 1'b0;
      ex_wwe_reg <= 1'b0;
      ex_fwe_reg <= 1'b0;
      ex_ill_reg <= 1'b0;
    end else if (cycle_end_o && state_next != idt_pkg::ST_SECOND) begin
      ex_word_reg <= prog_word_i;
      ex_group_reg <= dec_group;
      ex_two_reg <= dec_two;
      ex_skip_reg <= dec_skip;
      ex_cbr_reg <= dec_cbr;
      ex_jump_reg <= dec_jump;
      ex_wwe_reg <= dec_wwe;
      ex_fwe_reg <= dec_fwe;
      ex_ill_reg <= dec_ill;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ex_word2_reg <= idt_pkg::RST_WORD;
    end else if (cycle_end_o && state_next == idt_pkg::ST_SECOND) begin
      ex_word2_reg <= prog_word_i;
    end
  end

  // ----------------------------------------------------------------
  // program counter requests
  // ----------------------------------------------------------------
  // the load is issued in the first phase of the following cycle so the
  // target can be taken from the second word as it arrives
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_load_reg <= 1'b0;
      pc_target_reg <= 20'h00000;
      pc_rel_reg <= 1'b0;
    end else begin
      pc_load_reg <= cycle_end_o && live && (ex_jump_reg || (ex_cbr_reg && cond_true_i));
      if (cycle_end_o && live) begin
        if (ex_two_reg) begin
          pc_target_reg <= {prog_word_i[idt_pkg::WORD2_MSB:0], ex_word_reg[idt_pkg::LIT_MSB:0]};
          pc_rel_reg <= 1'b0;
        end else if (ex_cbr_reg) begin
          pc_target_reg <= {12'h000, ex_word_reg[idt_pkg::LIT_MSB:0]};
          pc_rel_reg <= 1'b1;
        end else begin
          pc_target_reg <= {9'h000, ex_word_reg[idt_pkg::BRA_MSB:0]};
          pc_rel_reg <= (ex_word_reg[15:idt_pkg::NIB_LSB] == 4'hD);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // cycle accounting
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_cnt_reg <= 2'h1;
      instr_done_reg <= 1'b0;
      instr_cycles_reg <= 2'h0;
    end else begin
      instr_done_reg <= 1'b0;
      if (cycle_end_o) begin
        if (state_next == idt_pkg::ST_RUN) begin
          instr_done_reg <= 1'b1;
          instr_cycles_reg <= cyc_cnt_reg;
          cyc_cnt_reg <= 2'h1;
        end else begin
          cyc_cnt_reg <= cyc_cnt_reg + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // a two-word instruction writes in its second cycle, when both words are held
  assign write_slot = cycle_end_o && !ex_ill_reg
    && ((live && !ex_two_reg) || state_reg == idt_pkg::ST_SECOND);

  assign working_register_we_o = write_slot && ex_wwe_reg;
  assign file_we_o = write_slot && ex_fwe_reg;
  assign alu_update_o = write_slot && ex_group_reg != idt_pkg::GRP_CTRL;
  assign nop_cycle_o = (state_reg == idt_pkg::ST_FLUSH);
  assign second_cycle_o = (state_reg == idt_pkg::ST_SECOND);

  assign group_o = ex_group_reg;
  assign file_addr_o = ex_word_reg[idt_pkg::FILE_MSB:0];
  assign dest_file_o = ex_word_reg[idt_pkg::DEST_BIT];
  assign access_bank_o = ex_word_reg[idt_pkg::ACC_BIT];
  assign bit_num_o = ex_word_reg[idt_pkg::BIT_MSB:idt_pkg::BIT_LSB];
  assign literal_o = ex_word_reg[idt_pkg::LIT_MSB:0];
  assign file_select_pointer_o = (ex_word_reg[15:8] == 8'hEE)
    ? ex_word_reg[idt_pkg::PTR_LOAD_LSB +: 2] : ex_word_reg[idt_pkg::PTR_EXT_LSB +: 2];
  assign fast_mode_o = (ex_word_reg[15:12] == 4'hE)
    ? ex_word_reg[idt_pkg::CALL_FAST_BIT] : ex_word_reg[idt_pkg::RET_FAST_BIT];
  assign table_mode_o = ex_word_reg[idt_pkg::TBL_MSB:0];
  assign second_word_o = ex_word2_reg[idt_pkg::WORD2_MSB:0];
  assign pc_load_o = pc_load_reg;
  assign pc_target_o = pc_target_reg;
  assign pc_relative_o = pc_rel_reg;
  assign instr_done_o = instr_done_reg;
  assign instr_cycles_o = instr_cycles_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_flush_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    nop_cycle_o |-> !working_register_we_o && !file_we_o && !alu_update_o)
    else $error("inserted no-op cycle wrote state");

  a_tail_alone: assert property (@(posedge clk_i) disable iff (rst_i)
    live && idt_pkg::idt_is_tail(ex_word_reg) |-> !working_register_we_o && !file_we_o && !pc_load_o)
    else $error("lone second word did not act as no-op");

  a_dest_select: assert property (@(posedge clk_i) disable iff (rst_i)
    working_register_we_o && group_o == idt_pkg::GRP_BYTE |-> !ex_word_reg[idt_pkg::DEST_BIT])
    else $error("byte result sent to working register with destination one");

  a_two_word_seq: assert property (@(posedge clk_i) disable iff (rst_i)
    cycle_end_o && live && ex_two_reg |=> second_cycle_o [*4] ##1 live)
    else $error("double-word instruction did not take two cycles");

  a_skip_flush: assert property (@(posedge clk_i) disable iff (rst_i)
    cycle_end_o && live && !ex_two_reg && ex_skip_reg && cond_true_i |=> nop_cycle_o [*4] ##1 live)
    else $error("taken skip did not insert one no-op cycle");

  a_jump_load: assert property (@(posedge clk_i) disable iff (rst_i)
    pc_load_o |-> (nop_cycle_o || second_cycle_o) && $past(cycle_end_o))
    else $error("program counter load outside a jump");

  a_single_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    cycle_end_o && live && !ex_two_reg && !ex_jump_reg && !ex_skip_reg && !ex_cbr_reg
    |=> instr_done_o && instr_cycles_o == 2'h1)
    else $error("plain instruction did not retire in one cycle");

  a_byte_group: assert property (@(posedge clk_i) disable iff (rst_i)
    !ex_ill_reg && ex_word_reg[15:12] inside {[4'h1:4'h6]} |-> group_o == idt_pkg::GRP_BYTE)
    else $error("byte opcode not classed as byte operation");

  a_skip_two: assert property (@(posedge clk_i) disable iff (rst_i)
    cycle_end_o && live && !ex_two_reg && ex_skip_reg && cond_true_i && dec_two
    |=> nop_cycle_o [*4] ##1 (live && idt_pkg::idt_is_tail(ex_word_reg))
    ##3 (cycle_end_o && live) ##1 instr_done_o)
    else $error("skip over double-word did not spend a third cycle");

  a_branch_rel: assert property (@(posedge clk_i) disable iff (rst_i)
    cycle_end_o && live && ex_cbr_reg && cond_true_i |=> pc_load_o && pc_relative_o && nop_cycle_o)
    else $error("taken conditional branch did not load a relative target");

  a_illegal_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    ex_ill_reg |-> !working_register_we_o && !file_we_o && !alu_update_o)
    else $error("refused opcode changed state");

  c_skip_taken: cover property (@(posedge clk_i) disable iff (rst_i)
    cycle_end_o && live && ex_skip_reg && cond_true_i);
  c_two_word: cover property (@(posedge clk_i) disable iff (rst_i)
    second_cycle_o && file_we_o);
  c_jump: cover property (@(posedge clk_i) disable iff (rst_i)
    pc_load_o && pc_relative_o);
  c_skip_over_two: cover property (@(posedge clk_i) disable iff (rst_i)
    cycle_end_o && live && ex_skip_reg && cond_true_i && dec_two);

endmodule
`default_nettype wire

// ===== sim/idt_prog_mem.sv
// program memory stand-in that feeds one instruction word per cycle
// assumes phase_i is the decoder's own phase count
`timescale 1ns/10ps
`default_nettype none
module idt_prog_mem (
  // request from bench
  input wire logic [15:0] word_i,
  // decoder timing
  input wire logic [1:0] phase_i,
  // word out
  output logic [15:0] word_o
);
  // ----------------------------------------------------------------
  // fetch
  // ----------------------------------------------------------------
  // outside the sampling phase the bus shows the inverse, so a sample taken
  // in the wrong phase cannot pass by luck
  assign word_o = (phase_i == 2'h3) ? word_i : ~word_i;
endmodule
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the instruction decode and timing block
// assumes idt_prog_mem stands in for program memory
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] req_w = 16'h0000;
  logic cond = 1'b0;
  logic ext = 1'b0;
  logic [15:0] prog_w;
  logic [1:0] phase, grp, fsp, tbl, ncyc;
  logic cyc_end, nop_c, sec_c, dst, acc, fast, wwe, fwe, alu, pcl, pcr, done;
  logic [7:0] fa, lit;
  logic [2:0] bn;
  logic [11:0] w2;
  logic [19:0] pct;
  int n_fail = 0;
  int comparisons = 0;

  always #50 clk_i = ~clk_i;

  idt_prog_mem mem (.word_i(req_w), .phase_i(phase), .word_o(prog_w));

  idt_decode_timing uut (
    .clk_i(clk_i), .rst_i(rst_i), .prog_word_i(prog_w), .cond_true_i(cond), .ext_mode_i(ext),
    .phase_o(phase), .cycle_end_o(cyc_end), .nop_cycle_o(nop_c), .second_cycle_o(sec_c),
    .group_o(grp), .file_addr_o(fa), .dest_file_o(dst), .access_bank_o(acc), .bit_num_o(bn),
    .literal_o(lit), .file_select_pointer_o(fsp), .fast_mode_o(fast), .table_mode_o(tbl), .second_word_o(w2),
    .working_register_we_o(wwe), .file_we_o(fwe), .alu_update_o(alu), .pc_load_o(pcl), .pc_target_o(pct),
    .pc_relative_o(pcr), .instr_done_o(done), .instr_cycles_o(ncyc)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task results;
    $display("fails %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input logic [23:0] g, input logic [23:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // presents one word (and a test result) in phase 3, then goes back to no-ops;
  // returns mid phase 0 of the following instruction cycle
  task slot(input logic [15:0] w, input logic c);
    int i;
    i = 0;
    @(negedge clk_i);
    while (phase !== 2'h2) begin
      i++;
      if (i > 8) begin
        n_fail++;
        results();
      end
      @(negedge clk_i);
    end
    @(posedge clk_i);
    req_w <= w;
    cond <= c;
    @(posedge clk_i);
    req_w <= 16'h0000;
    cond <= 1'b0;
    @(negedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] f;
    logic [11:0] k, k2;
    logic [2:0] b;
    logic d, a;
    logic [5:0] ops [8];
    void'($urandom(12));
    ops = '{6'h09, 6'h04, 6'h05, 6'h06, 6'h07, 6'h17, 6'h0A, 6'h01};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_i);
      chk(phase, 24'(i % 4));
      chk(cyc_end, 24'(i % 4 == 3));
    end
    // byte operations, random operands, extended mode toggling underneath
    for (int i = 0; i < 24; i++) begin
      f = 8'($urandom);
      d = 1'($urandom);
      a = 1'($urandom);
      @(posedge clk_i);
      ext <= 1'($urandom);
      slot({ops[i % 8], d, a, f}, 1'b0);
      chk(grp, 24'h0);
      chk({dst, acc, fa}, {d, a, f});
      repeat (3) @(negedge clk_i);
      chk({wwe, fwe, alu}, {!d, d, 1'b1});
      @(negedge clk_i);
      chk({done, ncyc}, 24'h5);
    end
    // bit set and clear
    for (int i = 0; i < 8; i++) begin
      f = 8'($urandom);
      b = 3'($urandom);
      a = 1'($urandom);
      slot({3'b100, i[0], b, a, f}, 1'b0);
      chk({grp, bn, acc, fa}, {2'h1, b, a, f});
      repeat (4) @(negedge clk_i);
      chk({done, ncyc}, 24'h5);
    end
    f = 8'($urandom);
    k = 12'($urandom);
    k2 = 12'($urandom);
    slot({8'h0E, f}, 1'b0);
    chk({grp, lit}, {2'h2, f});
    repeat (3) @(negedge clk_i);
    chk(wwe, 24'h1);
    slot(16'hEE25, 1'b0);
    slot(16'hF0AB, 1'b0);
    chk({grp, fsp, sec_c}, {2'h2, 2'h2, 1'b1});
    repeat (4) @(negedge clk_i);
    chk({done, ncyc}, 24'h6);
    for (int m = 0; m < 4; m++) begin
      slot(16'h0008 | 16'(m), 1'b0);
      chk({grp, tbl}, {2'h3, m[1:0]});
    end
    for (int s = 0; s < 2; s++) begin
      slot(16'h0012 | 16'(s), 1'b0);
      chk({grp, fast}, {2'h3, s[0]});
      repeat (4) @(negedge clk_i);
      chk({pcl, nop_c}, 24'h3);
      repeat (4) @(negedge clk_i);
      chk({done, ncyc}, 24'h6);
    end
    // two-word jump, then two-word move
    slot({8'hEF, f}, 1'b0);
    slot({4'hF, k}, 1'b0);
    chk({pcl, sec_c, pcr, pct}, {3'b110, k, f});
    repeat (4) @(negedge clk_i);
    chk({done, ncyc}, 24'h6);
    slot({4'hC, k}, 1'b0);
    slot({4'hF, k2}, 1'b0);
    chk({sec_c, w2}, {1'b1, k2});
    repeat (3) @(negedge clk_i);
    chk(fwe, 24'h1);
    @(negedge clk_i);
    chk({done, ncyc}, 24'h6);
    // a tail word on its own does nothing for one cycle
    slot({4'hF, k}, 1'b0);
    repeat (3) @(negedge clk_i);
    chk({wwe, fwe, alu, pcl}, 24'h0);
    @(negedge clk_i);
    chk({done, ncyc}, 24'h5);
    // compare-and-skip, test false then true
    for (int c = 0; c < 2; c++) begin
      slot({8'h62, f}, 1'b0);
      slot(16'h0000, c[0]);
      chk(nop_c, 24'(c));
      if (c == 1) begin
        repeat (3) @(negedge clk_i);
        chk({wwe, fwe, alu}, 24'h0);
        @(negedge clk_i);
      end
      chk({done, ncyc}, {1'b1, 2'(1 + c)});
    end
    // skip taken over a two-word move: two cycles plus a one-cycle tail
    slot({8'h62, f}, 1'b0);
    slot({4'hC, k}, 1'b1);
    slot({4'hF, k2}, 1'b0);
    chk({done, ncyc}, 24'h6);
    repeat (3) @(negedge clk_i);
    chk({wwe, fwe, alu}, 24'h0);
    @(negedge clk_i);
    chk({done, ncyc}, 24'h5);
    // extended opcode with the extension switched off is refused
    @(posedge clk_i);
    ext <= 1'b0;
    slot({8'hE8, f}, 1'b0);
    chk(grp, 24'h3);
    repeat (3) @(negedge clk_i);
    chk({wwe, fwe, alu, pcl}, 24'h0);
    // another extended opcode (EA) is accepted once the extension is on
    @(posedge clk_i);
    ext <= 1'b1;
    slot({8'hEA, f}, 1'b0);
    chk(grp, 24'h2);
    repeat (3) @(negedge clk_i);
    chk({wwe, fwe, alu}, 24'h1);
    // conditional branch taken: relative target and one no-op cycle
    slot({8'hE0, f}, 1'b0);
    slot(16'h0000, 1'b1);
    chk({pcl, nop_c, pcr, pct}, {3'b111, 12'h000, f});
    repeat (4) @(negedge clk_i);
    chk({done, ncyc}, 24'h6);
    results();
  end
endmodule
`default_nettype wire
